/* design/pcr_pkg.sv */
// package for the phy control register bank: offsets, field positions,
// reset values and the carrier types used by the bank and its receive helper.
// assumes a 32-bit axi4-lite bus with each register in one aligned word.
package pcr_pkg;

  // register indices; the byte address is four times the index
  localparam logic [3:0]  IDX_CONTROL_ONE   = 4'h9;
  localparam logic [3:0]  IDX_CONTROL_TWO   = 4'hA;
  localparam logic [3:0]  IDX_CONTROL_THREE = 4'hB;
  localparam int          ADDR_W            = 8;

  // reset values
  localparam logic [15:0] RST_CONTROL_ONE   = 16'h0000;
  localparam logic [15:0] RST_CONTROL_TWO   = 16'h0102;
  localparam logic [15:0] RST_CONTROL_THREE = 16'h0000;

  // control_one fields; bits 15:10 and 0 are read-only zero
  localparam int          C1_AUTO_TEST      = 8;
  localparam int          C1_ROBUST_XOVER   = 5;
  localparam int          C1_EARLY_RXDV     = 1;
  localparam logic [15:0] C1_WRITE_MASK     = 16'h03FE;

  // control_two fields
  localparam int          C2_EXT_FDX        = 5;
  localparam int          C2_IDLE_ERR       = 2;
  localparam int          C2_ODD_DIS        = 1;

  // axi response codes
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // one received code group from the symbol decoder
  typedef struct packed {
    logic valid;    // a new symbol this cycle
    logic is_j;     // first half of start-of-stream
    logic is_k;     // second half of start-of-stream
    logic is_idle;  // idle code group
    logic sym_err;  // invalid code group
    logic eos;      // end of stream seen
  } pcr_rx_sym_t;

  // link state used for the duplex decision
  typedef struct packed {
    logic an_enable;        // local side auto-negotiates
    logic forced_100;       // local side forced to 100 mbit
    logic partner_forced;   // partner detected as forced 100 mbit
    logic std_full_duplex;  // duplex by the standard resolution
  } pcr_link_t;

  // merge a write into a 16-bit register under byte strobes and a write mask
  function automatic logic [15:0] pcr_merge(input logic [15:0] old_v,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  wstrb,
                                            input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {wstrb[1] ? wdata[15:8] : old_v[15:8], wstrb[0] ? wdata[7:0] : old_v[7:0]};
    return (lane & wmask) | (old_v & ~wmask);
  endfunction

endpackage

/* design/pcr_rx_start.sv */
// receive start-of-stream detector: raises the data-valid flag on j/k
// or on j alone in early mode, and flags receive errors.
// assumes symbols arrive one per valid strobe, synchronous to sys_clk_i.
`timescale 1ns/1ps
module pcr_rx_start (
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  input  wire pcr_pkg::pcr_rx_sym_t sym_i,
  input  wire logic                 early_i,
  input  wire logic                 idle_det_i,
  output logic                      rx_dv_o,
  output logic                      rx_er_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_GOT_J, ST_FRAME} pcr_rx_state_t;
  pcr_rx_state_t state_q;

  // start-of-stream tracking and valid flag
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      rx_dv_o <= 1'b0;
    end else if (sym_i.valid) begin
      case (state_q)
        ST_IDLE: begin
          if (sym_i.is_j) begin
            state_q <= ST_GOT_J;
            if (early_i) rx_dv_o <= 1'b1;
          end
        end
        ST_GOT_J: begin
          if (sym_i.is_k) begin
            state_q <= ST_FRAME;
            rx_dv_o <= 1'b1;
          end else begin
            state_q <= ST_IDLE;
            rx_dv_o <= 1'b0;
          end
        end
        ST_FRAME: begin
          if (sym_i.eos) begin
            state_q <= ST_IDLE;
            rx_dv_o <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          rx_dv_o <= 1'b0;
        end
      endcase
    end
  end

  // receive error pulses
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_er_o <= 1'b0;
    end else begin
      rx_er_o <= 1'b0;
      if (sym_i.valid) begin
        if (state_q == ST_GOT_J && !sym_i.is_k && early_i) rx_er_o <= 1'b1;
        if (state_q == ST_IDLE && sym_i.is_idle && sym_i.sym_err && idle_det_i) begin
          rx_er_o <= 1'b1;
        end
      end
    end
  end

  early_err_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (sym_i.valid && state_q == ST_GOT_J && !sym_i.is_k && early_i) |=> rx_er_o && !rx_dv_o)
    else $error("no receive error after j without k");

  // no early valid in normal mode
  normal_dv_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (sym_i.valid && state_q == ST_IDLE && sym_i.is_j && !early_i && !rx_dv_o) |=> !rx_dv_o)
    else $error("valid raised on j alone in normal mode");

endmodule // pcr_rx_start

/* design/pcr_regs.sv */
// phy control register bank: three control registers on axi4-lite and the
// logic they steer (cable test launch, crossover, rx start, duplex, odd nibble).
// assumes all inputs synchronous to sys_clk_i; tx_clk_en_i marks mii tx nibbles.
//
// How it works
// - auto-run bit set: launch cable reflectometry test after each link drop.
// - bit 5 of control_one enables robust crossover resolution.
// - early bit clear: data-valid only after the full j/k pair.
// - early bit set: data-valid rises on j alone.
// - early mode: j not followed by k raises a receive error.
// - extended duplex bit clear: duplex follows the standard resolution.
// - extended bit set: forced-100 partner with an or forced 100 gives full duplex.
// - control_two bit 2 gates idle-time receive symbol error detection.
// - odd-nibble disable resets to 1; strap sets it in enhanced mode only.
// - enhanced mode: odd-nibble end extends tx enable one nibble carrying a transmit error.
// - control_two sits at index a and resets to 0102.
// - control_three sits at index b and resets to zero.
// - control_one sits at index 9 and resets to zero.
`timescale 1ns/1ps
module pcr_regs (
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // straps
  input  wire logic                 enhanced_mode_i,
  input  wire logic                 bootstrap_pin_one_i,
  // link and test
  input  wire logic                 link_up_i,
  output logic                      cable_reflectometry_test_o,
  output logic                      robust_xover_o,
  input  wire pcr_pkg::pcr_link_t   link_i,
  output logic                      full_duplex_o,
  // receive side
  input  wire pcr_pkg::pcr_rx_sym_t rx_sym_i,
  output logic                      rx_dv_o,
  output logic                      rx_er_o,
  // mii transmit side
  input  wire logic                 tx_clk_en_i,
  input  wire logic                 tx_en_i,
  input  wire logic                 tx_er_i,
  output logic                      tx_en_o,
  output logic                      tx_er_o
);

  logic [15:0] control_one_q;
  logic [15:0] control_two_q;
  logic [15:0] control_three_q;
  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic        strap_done_q;
  logic        link_up_q;
  logic        odd_q;
  logic        ext_q;

  // decode a byte address to a register index; low two bits must be zero
  function automatic logic [4:0] pcr_decode(input logic [7:0] addr);
    if (addr[1:0] != 2'h0) return 5'h1F;
    return {1'b0, addr[5:2]} | {addr[7:6] != 2'h0, 4'h0};
  endfunction

  // --- axi write path: address and data taken in either order ---
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // address channel holding register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // data channel holding register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (pcr_decode(aw_addr_q))
        {1'b0, pcr_pkg::IDX_CONTROL_ONE},
        {1'b0, pcr_pkg::IDX_CONTROL_TWO},
        {1'b0, pcr_pkg::IDX_CONTROL_THREE}: s_axi_bresp <= pcr_pkg::RESP_OKAY;
        default:                            s_axi_bresp <= pcr_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --- register storage ---
  // control_one reset and write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      control_one_q <= pcr_pkg::RST_CONTROL_ONE;
    end else if (wr_go && pcr_decode(aw_addr_q) == {1'b0, pcr_pkg::IDX_CONTROL_ONE}) begin
      control_one_q <= pcr_pkg::pcr_merge(control_one_q, w_data_q, w_strb_q,
                                          pcr_pkg::C1_WRITE_MASK);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      control_two_q <= pcr_pkg::RST_CONTROL_TWO;
      strap_done_q  <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      control_two_q[pcr_pkg::C2_ODD_DIS] <= enhanced_mode_i ? bootstrap_pin_one_i : 1'b1;
    end else if (wr_go && pcr_decode(aw_addr_q) == {1'b0, pcr_pkg::IDX_CONTROL_TWO}) begin
      control_two_q <= pcr_pkg::pcr_merge(control_two_q, w_data_q, w_strb_q, 16'hFFFF);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      control_three_q <= pcr_pkg::RST_CONTROL_THREE;
    end else if (wr_go && pcr_decode(aw_addr_q) == {1'b0, pcr_pkg::IDX_CONTROL_THREE}) begin
      control_three_q <= pcr_pkg::pcr_merge(control_three_q, w_data_q, w_strb_q, 16'hFFFF);
    end
  end

  // --- axi read path: one read at a time ---
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pcr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= pcr_pkg::RESP_OKAY;
        case (pcr_decode(s_axi_araddr))
          {1'b0, pcr_pkg::IDX_CONTROL_ONE}:   s_axi_rdata <= {16'h0000, control_one_q};
          {1'b0, pcr_pkg::IDX_CONTROL_TWO}:   s_axi_rdata <= {16'h0000, control_two_q};
          {1'b0, pcr_pkg::IDX_CONTROL_THREE}: s_axi_rdata <= {16'h0000, control_three_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pcr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --- link drop and cable test launch ---
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link_up_q                  <= 1'b0;
      cable_reflectometry_test_o <= 1'b0;
    end else begin
      link_up_q <= link_up_i;
      cable_reflectometry_test_o <= link_up_q && !link_up_i &&
                                    control_one_q[pcr_pkg::C1_AUTO_TEST];
    end
  end

  // crossover mode and duplex decision
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      robust_xover_o <= 1'b0;
      full_duplex_o  <= 1'b0;
    end else begin
      robust_xover_o <= control_one_q[pcr_pkg::C1_ROBUST_XOVER];
      if (control_two_q[pcr_pkg::C2_EXT_FDX] && link_i.partner_forced &&
          (link_i.an_enable || link_i.forced_100)) begin
        full_duplex_o <= 1'b1;
      end else begin
        full_duplex_o <= link_i.std_full_duplex;
      end
    end
  end

  // --- receive start-of-stream and idle errors ---
  pcr_rx_start pcr_rx_start_i (
    .sys_clk_i  (sys_clk_i),
    .srst_i     (srst_i),
    .sym_i      (rx_sym_i),
    .early_i    (control_one_q[pcr_pkg::C1_EARLY_RXDV]),
    .idle_det_i (control_two_q[pcr_pkg::C2_IDLE_ERR]),
    .rx_dv_o    (rx_dv_o),
    .rx_er_o    (rx_er_o)
  );

  // --- transmit odd-nibble end detection, one step per tx nibble ---
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_en_o <= 1'b0;
      tx_er_o <= 1'b0;
      odd_q   <= 1'b0;
      ext_q   <= 1'b0;
    end else if (tx_clk_en_i) begin
      if (tx_en_i) begin
        tx_en_o <= 1'b1;
        tx_er_o <= tx_er_i;
        odd_q   <= !odd_q;
        ext_q   <= 1'b0;
      end else if (tx_en_o && !ext_q && odd_q && enhanced_mode_i &&
                   !control_two_q[pcr_pkg::C2_ODD_DIS]) begin
        tx_en_o <= 1'b1;
        tx_er_o <= 1'b1;
        ext_q   <= 1'b1;
        odd_q   <= 1'b0;
      end else begin
        tx_en_o <= 1'b0;
        tx_er_o <= 1'b0;
        ext_q   <= 1'b0;
        odd_q   <= 1'b0;
      end
    end
  end

  // --- assertions ---
  // launch only on a drop with auto-run set
  auto_test_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cable_reflectometry_test_o |-> $past(link_up_q) && !$past(link_up_i) &&
    $past(control_one_q[pcr_pkg::C1_AUTO_TEST]))
    else $error("cable test launched without a link drop");

  robust_xover_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 robust_xover_o == $past(control_one_q[pcr_pkg::C1_ROBUST_XOVER]))
    else $error("robust crossover does not follow control bit");

  std_duplex_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !control_two_q[pcr_pkg::C2_EXT_FDX] ##1 !$past(srst_i) |->
    full_duplex_o == $past(link_i.std_full_duplex))
    else $error("duplex deviates from standard resolution");

  ext_duplex_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (control_two_q[pcr_pkg::C2_EXT_FDX] && link_i.partner_forced &&
     (link_i.an_enable || link_i.forced_100)) |=> full_duplex_o)
    else $error("extended full duplex not applied");

  odd_extend_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (tx_clk_en_i && !tx_en_i && tx_en_o && !ext_q && odd_q && enhanced_mode_i &&
     !control_two_q[pcr_pkg::C2_ODD_DIS]) |=> tx_en_o && tx_er_o && ext_q)
    else $error("odd nibble end not extended with error");

  common_pinout_mode_mode_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!enhanced_mode_i && tx_clk_en_i) |=> !ext_q)
    else $error("odd nibble extension in common_pinout_mode mode");

  // read-only bits of control_one stay zero
  ro_bits_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (control_one_q & ~pcr_pkg::C1_WRITE_MASK) == 16'h0000)
    else $error("read-only bits of control_one changed");

  // reset value of control_two before the strap load
  reset_two_a: assert property (@(posedge sys_clk_i)
    srst_i |=> control_two_q == pcr_pkg::RST_CONTROL_TWO && !strap_done_q)
    else $error("control_two reset value wrong");

  reset_one_a: assert property (@(posedge sys_clk_i)
    srst_i |=> control_one_q == pcr_pkg::RST_CONTROL_ONE && !s_axi_bvalid)
    else $error("control_one reset value wrong");

  // read answered one cycle after the address handshake
  read_answer_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered in time");

  // main scenarios
  wr_cover_c:   cover property (@(posedge sys_clk_i) disable iff (srst_i) wr_go);
  rd_cover_c:   cover property (@(posedge sys_clk_i) disable iff (srst_i)
    s_axi_rvalid && s_axi_rready);
  ext_cover_c:  cover property (@(posedge sys_clk_i) disable iff (srst_i) ext_q);
  test_cover_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    cable_reflectometry_test_o);

endmodule // pcr_regs

/* tb/pcr_mac_model.sv */
// mac transmit model: paces mii nibbles, sends frames of a chosen length.
// assumes the bench calls send() and shares clock and reset.
`timescale 1ns/1ps
module pcr_mac_model (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  output logic      tx_clk_en_o,
  output logic      tx_en_o,
  output logic      tx_er_o
);
  // one nibble strobe every other cycle
  always_ff @(posedge sys_clk_i) begin
    tx_clk_en_o <= srst_i ? 1'b0 : ~tx_clk_en_o;
  end
  // the mac flags its own transmit errors only when asked to
  initial begin
    tx_en_o = 1'b0;
    tx_er_o = 1'b0;
  end
  // enable and error move just after a strobe edge and hold across the next strobe
  task automatic send(input int n, input logic e);
    for (int i = 0; i <= n; i++) begin
      do @(posedge sys_clk_i); while (tx_clk_en_o !== 1'b1);
      tx_en_o <= (i < n);
      tx_er_o <= e && (i < n);
    end
    repeat (10) @(posedge sys_clk_i);
  endtask
endmodule // pcr_mac_model

/* tb/pcr_regs_bench.sv */
// self-checking bench for the phy control register bank.
// assumes pcr_pkg and pcr_mac_model compiled first; 40 mhz clock.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module pcr_regs_bench;
  localparam logic [7:0] A1 = {2'h0, pcr_pkg::IDX_CONTROL_ONE, 2'h0};
  localparam logic [7:0] A2 = {2'h0, pcr_pkg::IDX_CONTROL_TWO, 2'h0};
  localparam logic [7:0] A3 = {2'h0, pcr_pkg::IDX_CONTROL_THREE, 2'h0};
  localparam logic [1:0] OK = pcr_pkg::RESP_OKAY;
  localparam logic [1:0] SE = pcr_pkg::RESP_SLVERR;
  logic        sys_clk = 1'b0, srst = 1'b1, enh = 1'b1, strap = 1'b1, link_up = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  lnk = 4'h0;
  logic [5:0]  rxs = 6'h0;
  logic        awready, wready, bvalid, arready, rvalid, test_o, xover, fdx, dv, er;
  logic        tce, ten, ter, ten_o, ter_o;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_count = 0, n_compared = 0, ne = 0, nr = 0;

  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;

  pcr_regs pcr_regs_i (
    .sys_clk_i(sys_clk), .srst_i(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .enhanced_mode_i(enh), .bootstrap_pin_one_i(strap), .link_up_i(link_up),
    .cable_reflectometry_test_o(test_o), .robust_xover_o(xover),
    .link_i(pcr_pkg::pcr_link_t'(lnk)), .full_duplex_o(fdx),
    .rx_sym_i(pcr_pkg::pcr_rx_sym_t'(rxs)), .rx_dv_o(dv), .rx_er_o(er),
    .tx_clk_en_i(tce), .tx_en_i(ten), .tx_er_i(ter), .tx_en_o(ten_o), .tx_er_o(ter_o));

  pcr_mac_model pcr_mac_model_i (
    .sys_clk_i(sys_clk), .srst_i(srst), .tx_clk_en_o(tce), .tx_en_o(ten), .tx_er_o(ter));

  // count forwarded nibbles at each strobe
  always @(posedge sys_clk) begin
    if (tce === 1'b1) begin
      ne += (ten_o === 1'b1);
      nr += (ter_o === 1'b1);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    bit ad = 0, wd = 0, bd = 0;
    int t = 0;
    awaddr  <= a;
    wdata   <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bd && t < 100) begin
      @(posedge sys_clk);
      t++;
      if (awready === 1'b1 && !ad) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        bd = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    `CHK(bd, 1'b1)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ad = 0, bd = 0;
    int t = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!bd && t < 100) begin
      @(posedge sys_clk);
      t++;
      if (arready === 1'b1 && !ad) begin
        ad = 1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        bd = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    `CHK(bd, 1'b1)
  endtask

  task automatic cw(input logic [7:0] a, input logic [15:0] v, input logic [1:0] e);
    logic [1:0] r;
    wr(a, v, r);
    `CHK(r, e)
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, re)
  endtask

  // j, then s2, then end of stream; returns dv after j and after s2, and error pulses
  task automatic rx(input logic [5:0] s2, output logic d1, output logic d2, output int n);
    n = 0;
    @(posedge sys_clk);
    rxs <= 6'h30;
    @(posedge sys_clk);
    rxs <= s2;
    #1 d1 = dv;
    @(posedge sys_clk);
    rxs <= 6'h21;
    #1 d2 = dv;
    n += (er === 1'b1);
    repeat (3) begin
      @(posedge sys_clk);
      rxs <= 6'h00;
      #1 n += (er === 1'b1);
    end
    // end of stream or a broken start leaves valid low
    `CHK(dv, 1'b0)
    @(posedge sys_clk);
  endtask

  task automatic txf(input int nn, input logic e, input int en_e, input int er_e);
    int e0, r0;
    e0 = ne;
    r0 = nr;
    pcr_mac_model_i.send(nn, e);
    `CHK(ne - e0, en_e)
    `CHK(nr - r0, er_e)
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_regs;
    cr(A1, 32'h0000, OK);
    cr(A2, 32'h0102, OK);
    cr(A3, 32'h0000, OK);
    cr(8'h30, 32'h0, SE);
    cr(8'h25, 32'h0, SE);
    `CHK(xover, 1'b0)
    cw(A1, 16'hFFFF, OK);
    cr(A1, 32'h03FE, OK);
    `CHK(xover, 1'b1)
    cw(A1, 16'h0000, OK);
    repeat (2) @(posedge sys_clk);
    `CHK(xover, 1'b0)
    cw(A3, 16'hFFFF, OK);
    cr(A3, 32'hFFFF, OK);
    cw(A2, 16'hFFF9, OK);
    cr(A2, 32'hFFF9, OK);
    cw(A2, 16'h0102, OK);
    cw(8'h30, 16'h1234, SE);
    $display("test registers done");
  endtask

  task automatic t_auto;
    int n;
    cw(A1, 16'h0100, OK);
    for (int k = 1; k >= 0; k--) begin
      if (k == 0) cw(A1, 16'h0000, OK);
      @(posedge sys_clk);
      link_up <= 1'b0;
      n = 0;
      repeat (6) begin
        @(posedge sys_clk);
        #1 n += (test_o === 1'b1);
      end
      `CHK(n, k)
      @(posedge sys_clk);
      link_up <= 1'b1;
    end
    $display("test auto cable test done");
  endtask

  task automatic t_rx;
    logic d1, d2;
    int   n;
    for (int m = 0; m < 2; m++) begin
      cw(A1, {14'h0, m[0], 1'b0}, OK);
      rx(6'h28, d1, d2, n);
      `CHK(d1, m[0])
      `CHK(d2, 1'b1)
      `CHK(n, 0)
      rx(6'h20, d1, d2, n);
      `CHK(n, m)
      `CHK(d2, 1'b0)
      cw(A2, m ? 16'h0106 : 16'h0102, OK);
      @(posedge sys_clk);
      // symbol error flagged on an idle code group
      rxs <= 6'h26;
      n = 0;
      repeat (4) begin
        @(posedge sys_clk);
        rxs <= 6'h00;
        #1 n += (er === 1'b1);
      end
      `CHK(n, m)
      @(posedge sys_clk);
    end
    $display("test receive start done");
  endtask

  task automatic t_dup;
    logic [3:0] pat [4] = '{4'hA, 4'hB, 4'h6, 4'h2};
    logic [3:0] v;
    // robust crossover set before any forced setting
    cw(A1, 16'h0020, OK);
    for (int m = 0; m < 8; m++) begin
      v = pat[m % 4];
      @(posedge sys_clk);
      if (m % 4 == 0) cw(A2, m[2] ? 16'h0122 : 16'h0102, OK);
      lnk <= v;
      repeat (3) @(posedge sys_clk);
      #1 `CHK(fdx, (m[2] & (v[3] | v[2]) & v[1]) | v[0])
    end
    $display("test duplex done");
  endtask

  task automatic t_tx;
    logic [31:0] d;
    logic [1:0]  r;
    txf(3, 1'b0, 3, 0);
    rd(A2, d, r);
    // read-modify-write keeps the reserved fields intact
    cw(A2, d[15:0] & 16'hFFFD, OK);
    txf(3, 1'b0, 4, 1);
    txf(4, 1'b0, 4, 0);
    // errors from the mac pass through on an even frame
    txf(4, 1'b1, 4, 4);
    @(posedge sys_clk);
    enh <= 1'b0;
    txf(3, 1'b0, 3, 0);
    @(posedge sys_clk);
    enh   <= 1'b1;
    srst  <= 1'b1;
    strap <= 1'b0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    cr(A2, 32'h0100, OK);
    txf(3, 1'b0, 4, 1);
    $display("test odd nibble done");
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_auto;
    t_rx;
    t_dup;
    t_tx;
    test_done;
  end

  // watchdog
  initial begin
    repeat (8000) @(posedge sys_clk);
    err_count++;
    test_done;
  end
endmodule // pcr_regs_bench
